// ### host_port_pkg.sv
package host_port_pkg;

  typedef enum logic [2:0] {
    REG_NONE   = 3'b000,
    REG_COMMON = 3'b001,
    REG_SOCKET = 3'b010,
    REG_TXBUF  = 3'b011,
    REG_RXBUF  = 3'b100
  } region_e;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_SOCKETS = 4;
  localparam int EVENTS_PER_SOCKET = 4;
  localparam int BUF_AW = 14;
  localparam int BUF_BYTES = 16384;
  localparam int COMMON_AW = 6;
  localparam int SOCKET_AW = 8;
  localparam int STRAP_W = 4;

  // Address map
  localparam logic [14:0] COMMON_END = 15'h0030;
  localparam logic [14:0] SOCKET_BASE = 15'h0400;
  localparam logic [14:0] SOCKET_END = 15'h0800;
  localparam logic [14:0] TXBUF_BASE = 15'h4000;
  localparam logic [14:0] RXBUF_BASE = 15'h6000;
  localparam logic [7:0] SOCKET_USED = 8'h30;
  localparam logic [14:0] GIR_ADDR = 15'h0015;
  localparam logic [14:0] IMR_ADDR = 15'h0016;
  localparam logic [5:0] SIR_OFS = 6'h02;

  // Offsets and reset values of common registers
  localparam logic [5:0] RTR_HI_OFS = 6'h17;
  localparam logic [5:0] RTR_LO_OFS = 6'h18;
  localparam logic [5:0] RCR_OFS = 6'h19;
  localparam logic [5:0] RMSR_OFS = 6'h1A;
  localparam logic [5:0] TMSR_OFS = 6'h1B;
  localparam logic [7:0] RTR_HI_RST = 8'h07;
  localparam logic [7:0] RTR_LO_RST = 8'hD0;
  localparam logic [7:0] RCR_RST = 8'h08;
  localparam logic [7:0] MSR_RST = 8'h55;

  // Strap codes
  localparam logic [3:0] STRAP_NORMAL = 4'h0;
  localparam logic [3:0] STRAP_PHY_TEST = 4'hF;

  // Host reset minimum hold
  localparam int RESET_MIN_NS = 2000;
  localparam int CLK_MHZ = 125;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CNT_W = 9;

  // Serial frame: opcode, address high, address low, data
  localparam logic [7:0] SPI_OP_WRITE = 8'hF0;
  localparam logic [7:0] SPI_OP_READ = 8'h0F;
  localparam logic [5:0] SPI_OP_BITS = 6'd8;
  localparam logic [5:0] SPI_ADDR_BITS = 6'd24;
  localparam logic [5:0] SPI_FRAME_BITS = 6'd32;

endpackage

// ### spi_slave_port.sv
`timescale 1ns/1ns
module spi_slave_port
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Mode
  input wire logic enable,
  // Serial pins
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Access request
  output logic wr_req,
  output logic rd_req,
  output logic [host_port_pkg::ADDR_W-1:0] acc_addr,
  output logic [host_port_pkg::DATA_W-1:0] acc_wdata,
  input wire logic [host_port_pkg::DATA_W-1:0] acc_rdata
);
  import host_port_pkg::*;

  logic [2:0] sync_a_ff;
  logic [2:0] sync_b_ff;
  logic sclk_d_ff;
  logic [5:0] bit_cnt_ff;
  logic [31:0] shin_ff;
  logic [7:0] shout_ff;
  logic load_pend_ff;
  logic wr_req_ff;
  logic rd_req_ff;
  logic sclk_s;
  logic sel_s;
  logic rise;
  logic fall;
  logic [31:0] nxt_shin;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a_ff <= 3'h7;
      sync_b_ff <= 3'h7;
      sclk_d_ff <= 1'b0;
    end else begin
      sync_a_ff <= {sclk, scs_n, mosi};
      sync_b_ff <= sync_a_ff;
      sclk_d_ff <= sync_b_ff[2];
    end
  end

  assign sclk_s = sync_b_ff[2];
  assign sel_s = enable && !sync_b_ff[1];
  // edges for modes 0 and 3
  assign rise = sel_s && sclk_s && !sclk_d_ff;
  assign fall = sel_s && !sclk_s && sclk_d_ff;
  assign nxt_shin = {shin_ff[30:0], sync_b_ff[0]};

  ////////////////////////////////////////////////////////////////
  // Receive side and requests
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= 6'd0;
      shin_ff <= 32'h0000_0000;
      wr_req_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end else begin
      wr_req_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      if (!sel_s) begin
        bit_cnt_ff <= 6'd0;
      end else if (rise && bit_cnt_ff < SPI_FRAME_BITS) begin
        shin_ff <= nxt_shin;
        bit_cnt_ff <= bit_cnt_ff + 6'd1;
        if (bit_cnt_ff == SPI_ADDR_BITS - 6'd1 && nxt_shin[23:16] == SPI_OP_READ) begin
          rd_req_ff <= 1'b1;
        end
        if (bit_cnt_ff == SPI_FRAME_BITS - 6'd1 && nxt_shin[31:24] == SPI_OP_WRITE) begin
          wr_req_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Transmit side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_pend_ff <= 1'b0;
      shout_ff <= 8'h00;
    end else begin
      load_pend_ff <= rd_req_ff;
      if (load_pend_ff) begin
        shout_ff <= acc_rdata;
      end else if (fall && bit_cnt_ff > SPI_ADDR_BITS) begin
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
    end
  end

  assign wr_req = wr_req_ff;
  assign rd_req = rd_req_ff;
  // Read requests issue once the address is in, write requests once the data byte behind it is in
  assign acc_addr = (bit_cnt_ff == SPI_FRAME_BITS) ? shin_ff[ADDR_W-1+8:8] : shin_ff[ADDR_W-1:0];
  assign acc_wdata = shin_ff[7:0];
  assign miso = shout_ff[7];
  assign miso_oe_n = !sel_s;

endmodule

// ### host_bus_port.sv
`timescale 1ns/1ns
module host_bus_port
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_reset_n,
  // Parallel bus
  input wire logic [host_port_pkg::ADDR_W-1:0] addr,
  input wire logic [host_port_pkg::DATA_W-1:0] data_in,
  output logic [host_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  output logic int_n,
  // Serial port
  input wire logic serial_port_select,
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Straps and mode
  input wire logic [host_port_pkg::STRAP_W-1:0] factory_test_select,
  output logic phy_test_mode,
  output logic normal_mode,
  // Protocol engine events
  input wire logic [15:0] socket_event_set,
  input wire logic [3:0] global_event_set,
  // PHY status and LEDs
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic rx_active,
  input wire logic tx_active,
  output logic link_good_led_n,
  output logic speed_100_led_n,
  output logic full_duplex_led_n,
  output logic collision_led_n,
  output logic receive_activity_led_n,
  output logic transmit_activity_led_n
);
  import host_port_pkg::*;

  localparam int PIN_W = 1 + ADDR_W + DATA_W + 3 + 1 + STRAP_W;

  logic [PIN_W-1:0] sync_a_ff;
  logic [PIN_W-1:0] sync_b_ff;
  logic wr_d_ff;
  logic [RESET_CNT_W-1:0] host_low_cnt_ff;
  logic strap_done_ff;
  logic [1:0] fill_ff;
  logic serial_mode_ff;
  logic [STRAP_W-1:0] strap_ff;
  logic [7:0] common_mem [0:(1<<COMMON_AW)-1];
  logic [7:0] socket_mem [0:NUM_SOCKETS*(1<<COMMON_AW)-1];
  logic [7:0] buf_mem [0:BUF_BYTES-1];
  logic [7:0] sock_flags_ff [0:NUM_SOCKETS-1];
  logic [3:0] glob_flags_ff;
  logic [7:0] ir_mask_ff;
  logic int_n_ff;
  logic [7:0] data_out_ff;
  logic oe_n_ff;
  logic [5:0] led_n_ff;
  logic reset_low_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic cs_s;
  logic wr_s;
  logic rd_s;
  logic soft_rst;
  logic par_read;
  logic par_write;
  logic spi_wr;
  logic spi_rd;
  logic [ADDR_W-1:0] spi_addr;
  logic [DATA_W-1:0] spi_wdata;
  logic acc_wr;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [7:0] rd_byte;
  logic [7:0] gir_value;
  logic [3:0] sock_any;

  function automatic region_e decode(input logic [ADDR_W-1:0] a);
    if (a < COMMON_END) begin
      decode = REG_COMMON;
    end else if (a >= SOCKET_BASE && a < SOCKET_END && a[7:0] < SOCKET_USED) begin
      decode = REG_SOCKET;
    end else if (a >= RXBUF_BASE) begin
      decode = REG_RXBUF;
    end else if (a >= TXBUF_BASE) begin
      decode = REG_TXBUF;
    end else begin
      decode = REG_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a_ff <= '1;
      sync_b_ff <= '1;
      wr_d_ff <= 1'b1;
    end else begin
      sync_a_ff <= {!host_reset_n, addr, data_in, cs_n, wr_n, rd_n, serial_port_select, factory_test_select};
      sync_b_ff <= sync_a_ff;
      wr_d_ff <= wr_s;
    end
  end

  assign {reset_low_s, addr_s, data_s, cs_s, wr_s, rd_s} = sync_b_ff[PIN_W-1:STRAP_W+1];

  ////////////////////////////////////////////////////////////////
  // Host reset filter and straps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_low_cnt_ff <= '0;
    end else if (!reset_low_s) begin
      host_low_cnt_ff <= '0;
    end else if (host_low_cnt_ff != RESET_CNT_W'(RESET_MIN_CYC)) begin
      host_low_cnt_ff <= host_low_cnt_ff + RESET_CNT_W'(1);
    end
  end

  assign soft_rst = reset_low_s && host_low_cnt_ff == RESET_CNT_W'(RESET_MIN_CYC);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fill_ff <= 2'b00;
      strap_done_ff <= 1'b0;
      serial_mode_ff <= 1'b0;
      strap_ff <= STRAP_NORMAL;
    end else begin
      fill_ff <= {fill_ff[0], 1'b1};
      // Straps read only once the synchronisers hold real pin levels
      if ((fill_ff[1] && !strap_done_ff) || soft_rst) begin
        strap_done_ff <= 1'b1;
        serial_mode_ff <= sync_b_ff[STRAP_W];
        strap_ff <= sync_b_ff[STRAP_W-1:0];
      end
    end
  end

  assign phy_test_mode = strap_ff == STRAP_PHY_TEST;
  assign normal_mode = strap_ff == STRAP_NORMAL;

  ////////////////////////////////////////////////////////////////
  // Access selection
  spi_slave_port u_spi (
    .core_clk(core_clk),
    .rst(rst),
    .enable(serial_mode_ff),
    .sclk(sclk),
    .scs_n(scs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .wr_req(spi_wr),
    .rd_req(spi_rd),
    .acc_addr(spi_addr),
    .acc_wdata(spi_wdata),
    .acc_rdata(data_out_ff)
  );

  assign par_read = !serial_mode_ff && !cs_s && !rd_s;
  assign par_write = !serial_mode_ff && !cs_s && wr_s && !wr_d_ff;
  assign acc_wr = par_write || spi_wr;
  assign acc_addr = serial_mode_ff ? spi_addr : addr_s;
  assign acc_wdata = serial_mode_ff ? spi_wdata : data_s;

  ////////////////////////////////////////////////////////////////
  // Register and buffer storage
  // bytes stored as addressed, high byte lowest
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < (1 << COMMON_AW); i++) begin
        common_mem[i] <= 8'h00;
      end
      common_mem[RTR_HI_OFS] <= RTR_HI_RST;
      common_mem[RTR_LO_OFS] <= RTR_LO_RST;
      common_mem[RCR_OFS] <= RCR_RST;
      common_mem[RMSR_OFS] <= MSR_RST;
      common_mem[TMSR_OFS] <= MSR_RST;
      for (int i = 0; i < NUM_SOCKETS * (1 << COMMON_AW); i++) begin
        socket_mem[i] <= 8'h00;
      end
    // defaults after a long host reset
    end else if (soft_rst) begin
      for (int i = 0; i < (1 << COMMON_AW); i++) begin
        common_mem[i] <= 8'h00;
      end
      common_mem[RTR_HI_OFS] <= RTR_HI_RST;
      common_mem[RTR_LO_OFS] <= RTR_LO_RST;
      common_mem[RCR_OFS] <= RCR_RST;
      common_mem[RMSR_OFS] <= MSR_RST;
      common_mem[TMSR_OFS] <= MSR_RST;
      for (int i = 0; i < NUM_SOCKETS * (1 << COMMON_AW); i++) begin
        socket_mem[i] <= 8'h00;
      end
    end else if (acc_wr) begin
      case (decode(acc_addr))
        REG_COMMON: common_mem[acc_addr[COMMON_AW-1:0]] <= acc_wdata;
        REG_SOCKET: socket_mem[{acc_addr[9:8], acc_addr[COMMON_AW-1:0]}] <= acc_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (acc_wr && (decode(acc_addr) == REG_TXBUF || decode(acc_addr) == REG_RXBUF)) begin
      buf_mem[acc_addr[BUF_AW-1:0]] <= acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Event flags and interrupt
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        sock_flags_ff[s] <= 8'h00;
      end
      glob_flags_ff <= 4'h0;
      ir_mask_ff <= 8'h00;
    end else if (soft_rst) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        sock_flags_ff[s] <= 8'h00;
      end
      glob_flags_ff <= 4'h0;
      ir_mask_ff <= 8'h00;
    end else begin
      // write one clears, a new event wins
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        sock_flags_ff[s] <= (sock_flags_ff[s]
          & ~((acc_wr && acc_addr == (SOCKET_BASE | ADDR_W'(s << SOCKET_AW) | ADDR_W'(SIR_OFS))) ? acc_wdata : 8'h00)
          & ~((acc_wr && acc_addr == GIR_ADDR && acc_wdata[s]) ? 8'hFF : 8'h00))
          | {4'h0, socket_event_set[s*EVENTS_PER_SOCKET +: EVENTS_PER_SOCKET]};
      end
      glob_flags_ff <= (glob_flags_ff & ~((acc_wr && acc_addr == GIR_ADDR) ? acc_wdata[7:4] : 4'h0))
        | global_event_set;
      if (acc_wr && acc_addr == IMR_ADDR) begin
        ir_mask_ff <= acc_wdata;
      end
    end
  end

  always_comb begin
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      sock_any[s] = |sock_flags_ff[s];
    end
  end

  assign gir_value = {glob_flags_ff, sock_any};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_n_ff <= 1'b1;
    end else begin
      int_n_ff <= !(|(gir_value & ir_mask_ff));
    end
  end

  assign int_n = int_n_ff;

  ////////////////////////////////////////////////////////////////
  // Read path
  // select one byte by address
  always_comb begin
    rd_byte = 8'h00;
    case (decode(acc_addr))
      REG_COMMON: begin
        if (acc_addr == GIR_ADDR) begin
          rd_byte = gir_value;
        end else if (acc_addr == IMR_ADDR) begin
          rd_byte = ir_mask_ff;
        end else begin
          rd_byte = common_mem[acc_addr[COMMON_AW-1:0]];
        end
      end
      REG_SOCKET: begin
        if (acc_addr[COMMON_AW-1:0] == SIR_OFS) begin
          rd_byte = sock_flags_ff[acc_addr[9:8]];
        end else begin
          rd_byte = socket_mem[{acc_addr[9:8], acc_addr[COMMON_AW-1:0]}];
        end
      end
      REG_TXBUF, REG_RXBUF: rd_byte = buf_mem[acc_addr[BUF_AW-1:0]];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_out_ff <= 8'h00;
      oe_n_ff <= 1'b1;
    end else begin
      data_out_ff <= rd_byte;
      oe_n_ff <= !par_read;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe_n = oe_n_ff;

  ////////////////////////////////////////////////////////////////
  // Status LEDs
  // link, speed, duplex, collision and activity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      led_n_ff <= 6'h3F;
    end else begin
      led_n_ff <= ~{link_up, speed_100, full_duplex, collision, rx_active, tx_active};
    end
  end

  assign {link_good_led_n, speed_100_led_n, full_duplex_led_n} = led_n_ff[5:3];
  assign {collision_led_n, receive_activity_led_n, transmit_activity_led_n} = led_n_ff[2:0];

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_hold_time: assert property (soft_rst |-> $past(reset_low_s, 200) && $past(reset_low_s, 1))
    else $error("host reset taken before hold time");
  a_reset_clears_mask: assert property (soft_rst |=> ir_mask_ff == 8'h00 ##1 int_n)
    else $error("mask or interrupt survived host reset");
  a_bus_release: assert property (!data_oe_n |-> $past(!cs_s && !rd_s && !serial_mode_ff))
    else $error("data bus driven outside a read");
  a_serial_quiet: assert property (serial_mode_ff |=> data_oe_n)
    else $error("parallel bus driven in serial mode");
  a_event_raises: assert property ((socket_event_set[0] && !soft_rst) ##1 (ir_mask_ff[0] && !soft_rst) |=> !int_n)
    else $error("masked-in socket event did not raise interrupt");
  a_mask_blocks: assert property (ir_mask_ff == 8'h00 [*2] |-> int_n)
    else $error("interrupt with all sources masked");
  a_flag_set_wins: assert property ((socket_event_set[0] && !soft_rst) |=> sock_flags_ff[0][0])
    else $error("socket event lost");
  a_strap_capture: assert property ($rose(strap_done_ff) |->
    phy_test_mode == ($past(sync_b_ff[STRAP_W-1:0]) == STRAP_PHY_TEST)
    && normal_mode == ($past(sync_b_ff[STRAP_W-1:0]) == STRAP_NORMAL))
    else $error("test mode strap not captured");
  a_led_link: assert property (link_up |=> !link_good_led_n)
    else $error("link LED not lit");
  a_led_duplex: assert property (!full_duplex |=> full_duplex_led_n)
    else $error("duplex LED lit in half duplex");

endmodule

// ### spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
  // Serial pins
  output logic sclk,
  output logic scs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    scs_n = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode 0 or 3 frame
  task automatic xfer(input logic cpol, input logic [31:0] word, output logic [7:0] rd);
    rd = 8'h00;
    sclk = cpol;
    #64;
    scs_n = 1'b0;
    #32;
    for (int i = 31; i >= 0; i--) begin
      mosi = word[i];
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
      rd = {rd[6:0], miso};
      #32;
    end
    sclk = cpol;
    #32;
    scs_n = 1'b1;
    // Released line shows the inverse
    mosi = ~mosi;
  endtask
endmodule

// ### host_bus_port_tb_top.sv
`timescale 1ns/1ns
module host_bus_port_tb_top;
  import host_port_pkg::*;
  logic core_clk;
  logic rst;
  logic host_reset_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic data_oe_n;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic int_n;
  logic serial_port_select;
  logic sclk;
  logic scs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic [STRAP_W-1:0] factory_test_select;
  logic phy_test_mode;
  logic normal_mode;
  logic [15:0] socket_event_set;
  logic [3:0] global_event_set;
  logic [5:0] phy_st;
  logic [5:0] leds_n;
  logic [7:0] rd;
  int mismatches;
  int compares;
  int cycles;
  logic [14:0] wa [7] = '{15'h0001, 15'h0400, 15'h0500, 15'h0600, 15'h0700, 15'h4000, 15'h7FFF};
  logic [14:0] ra [6] = '{15'h0016, 15'h0017, 15'h0018, 15'h0019, 15'h001A, 15'h001B};
  logic [7:0] rv [6] = '{8'h00, 8'h07, 8'hD0, 8'h08, 8'h55, 8'h55};

  host_bus_port i_host_bus_port (
    .core_clk(core_clk), .rst(rst), .host_reset_n(host_reset_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .int_n(int_n),
    .serial_port_select(serial_port_select), .sclk(sclk), .scs_n(scs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .factory_test_select(factory_test_select), .phy_test_mode(phy_test_mode),
    .normal_mode(normal_mode), .socket_event_set(socket_event_set), .global_event_set(global_event_set),
    .link_up(phy_st[5]), .speed_100(phy_st[4]), .full_duplex(phy_st[3]), .collision(phy_st[2]),
    .rx_active(phy_st[1]), .tx_active(phy_st[0]), .link_good_led_n(leds_n[5]),
    .speed_100_led_n(leds_n[4]), .full_duplex_led_n(leds_n[3]), .collision_led_n(leds_n[2]),
    .receive_activity_led_n(leds_n[1]), .transmit_activity_led_n(leds_n[0])
  );

  spi_host_model i_spi_host_model (.sclk(sclk), .scs_n(scs_n), .mosi(mosi), .miso(miso));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [14:0] a, input logic [7:0] d);
    addr = a;
    data_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    step(5);
    wr_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    step(3);
  endtask

  task automatic bus_rd(input logic [14:0] a, input logic [7:0] exp);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (int i = 0; i < 10 && data_oe_n !== 1'b0; i++) step(1);
    step(1);
    chk(data_oe_n, 8'h00);
    chk(data_out, exp);
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(4);
  endtask

  task automatic hreset(input int n);
    host_reset_n = 1'b0;
    step(n);
    host_reset_n = 1'b1;
    step(6);
  endtask

  task automatic pulse(input logic [15:0] ev);
    socket_event_set = ev;
    step(1);
    socket_event_set = 16'h0000;
    step(3);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {mismatches, compares, cycles} = '0;
    rst = 1'b1;
    host_reset_n = 1'b1;
    {addr, data_in} = '0;
    {cs_n, wr_n, rd_n} = 3'b111;
    serial_port_select = 1'b0;
    factory_test_select = 4'h0;
    socket_event_set = 16'h0000;
    global_event_set = 4'h0;
    phy_st = 6'h00;
    step(2);
    rst = 1'b0;
    step(6);
    chk(data_oe_n, 8'h01);
    chk({phy_test_mode, normal_mode}, 8'h01);
    for (int i = 0; i < 6; i++) bus_rd(ra[i], rv[i]);
    for (int i = 0; i < 7; i++) bus_wr(wa[i], 8'h11 + 8'(i * 17));
    for (int i = 0; i < 7; i++) bus_rd(wa[i], 8'h11 + 8'(i * 17));
    bus_wr(15'h0030, 8'hA5);
    bus_rd(15'h0030, 8'h00);
    bus_rd(15'h0800, 8'h00);
    bus_wr(15'h0016, 8'h0F);
    pulse(16'h0040);
    chk(int_n, 8'h00);
    bus_rd(15'h0502, 8'h04);
    bus_rd(15'h0015, 8'h02);
    bus_wr(15'h0502, 8'h04);
    chk(int_n, 8'h01);
    bus_wr(15'h0016, 8'h00);
    pulse(16'h0001);
    chk(int_n, 8'h01);
    bus_rd(15'h0015, 8'h01);
    bus_wr(15'h0015, 8'h01);
    bus_rd(15'h0402, 8'h00);
    bus_wr(15'h0016, 8'h01);
    pulse(16'h0001);
    chk(int_n, 8'h00);
    bus_wr(15'h0402, 8'h01);
    chk(int_n, 8'h01);
    global_event_set = 4'h1;
    step(1);
    global_event_set = 4'h0;
    step(3);
    bus_rd(15'h0015, 8'h10);
    bus_wr(15'h0015, 8'h10);
    bus_rd(15'h0015, 8'h00);
    for (int i = 0; i < 6; i++) begin
      phy_st = 6'(1 << i);
      step(2);
      chk({2'b00, leds_n}, ~(8'(1 << i)) & 8'h3F);
    end
    phy_st = 6'h00;
    hreset(100);
    bus_rd(15'h0001, 8'h11);
    factory_test_select = 4'hF;
    serial_port_select = 1'b1;
    hreset(300);
    chk({phy_test_mode, normal_mode}, 8'h02);
    addr = 15'h0017;
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(6);
    chk(data_oe_n, 8'h01);
    {cs_n, rd_n} = 2'b11;
    step(2);
    i_spi_host_model.xfer(1'b0, {SPI_OP_READ, 16'h0001, 8'h00}, rd);
    chk(rd, 8'h00);
    i_spi_host_model.xfer(1'b0, {SPI_OP_WRITE, 16'h0500, 8'h3C}, rd);
    step(4);
    i_spi_host_model.xfer(1'b1, {SPI_OP_READ, 16'h0500, 8'h00}, rd);
    chk(rd, 8'h3C);
    i_spi_host_model.xfer(1'b1, {SPI_OP_READ, 16'h0018, 8'h00}, rd);
    chk(rd, 8'hD0);
    tally_and_finish();
  end
endmodule
